/* File: hdl/ehrpc_params.svh */
// Constants for the root port control block
`ifndef EHRPC_PARAMS_SVH
`define EHRPC_PARAMS_SVH
`define EHRPC_ADDR_W     8
`define EHRPC_DATA_W     32
`define EHRPC_OFS_STS    8'h04
`define EHRPC_OFS_CFG    8'h50
`define EHRPC_OFS_PSC    8'h54
`define EHRPC_OFS_PWR    8'h58
`define EHRPC_B_HALT     0
`define EHRPC_B_CF       0
`define EHRPC_B_PWR      0
`define EHRPC_B_OWNER    13
`define EHRPC_B_PRST     8
`define EHRPC_B_SUSP     7
`define EHRPC_B_FPR      6
`define EHRPC_B_PE       2
`define EHRPC_RST_OWNER  1'h1
`define EHRPC_RST_PWR    1'h1
`define EHRPC_RESP_OKAY  2'h0
`define EHRPC_RESP_SLV   2'h2
`define EHRPC_CLK_NS     10
`define EHRPC_SETTLE_NS  10000
`define EHRPC_CNT_W      11
`define EHRPC_SETTLE_CYC (`EHRPC_SETTLE_NS / `EHRPC_CLK_NS)
`define EHRPC_CNT_LAST   11'(`EHRPC_SETTLE_CYC - 1)
`define EHRPC_CNT_ZERO   11'h0
`define EHRPC_CNT_ONE    11'h1
`endif

/* File: hdl/ehrpc_pkg.sv */
// Types for the root port control block
package ehrpc_pkg;
  typedef enum logic [1:0] {PS_IDLE, PS_RESET, PS_RST_END, PS_RES_END} ehrpc_pst_t;
  typedef enum logic [2:0] {SEL_NONE, SEL_STS, SEL_CFG, SEL_PSC, SEL_PWR} ehrpc_sel_t;
  typedef enum logic [1:0] {MODE_DIS, MODE_EN, MODE_SUSP} ehrpc_mode_t;
  typedef struct packed {
    logic [17:0] rsvd_hi;
    logic        owner;
    logic        rsvd12;
    logic [1:0]  line;
    logic        rsvd9;
    logic        prst;
    logic        susp;
    logic        fpr;
    logic [2:0]  rsvd5_3;
    logic        pe;
    logic        csc;
    logic        ccs;
  } ehrpc_root_port_status_control_t;
endpackage : ehrpc_pkg

/* File: hdl/ehrpc_top.sv */
// Root port ownership, reset, enable and suspend control with AXI4-Lite registers
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ehrpc_params.svh"
module ehrpc_top
(
  input  wire logic                       I_SYS_CLK,
  input  wire logic                       I_RST,
  input  wire logic                       I_AWVALID,
  output var  logic                       O_AWREADY,
  input  wire logic [`EHRPC_ADDR_W-1:0]   I_AWADDR,
  input  wire logic                       I_WVALID,
  output var  logic                       O_WREADY,
  input  wire logic [`EHRPC_DATA_W-1:0]   I_WDATA,
  input  wire logic [3:0]                 I_WSTRB,
  output var  logic                       O_BVALID,
  input  wire logic                       I_BREADY,
  output var  logic [1:0]                 O_BRESP,
  input  wire logic                       I_ARVALID,
  output var  logic                       O_ARREADY,
  input  wire logic [`EHRPC_ADDR_W-1:0]   I_ARADDR,
  output var  logic                       O_RVALID,
  input  wire logic                       I_RREADY,
  output var  logic [`EHRPC_DATA_W-1:0]   O_RDATA,
  output var  logic [1:0]                 O_RRESP,
  input  wire logic                       I_LINE_DP,
  input  wire logic                       I_LINE_DM,
  input  wire logic                       I_DEV_CONNECT,
  input  wire logic                       I_DEV_HIGH_SPEED,
  input  wire logic                       I_XACT_BUSY,
  input  wire logic                       I_RESUME_DET,
  input  wire logic                       I_CONTROLLER_STOPPED_INDICATION,
  output var  logic                       O_PORT_OWNER,
  output var  logic                       O_BUS_RESET,
  output var  logic                       O_RESUME_DRIVE,
  output var  logic                       O_DS_BLOCK,
  output var  ehrpc_pkg::ehrpc_mode_t     O_PORT_MODE
);

  function automatic ehrpc_pkg::ehrpc_sel_t sel_of(input logic [`EHRPC_ADDR_W-1:0] addr);
    ehrpc_pkg::ehrpc_sel_t s;
    s = ehrpc_pkg::SEL_NONE;
    case (addr)
      `EHRPC_OFS_STS: s = ehrpc_pkg::SEL_STS;
      `EHRPC_OFS_CFG: s = ehrpc_pkg::SEL_CFG;
      `EHRPC_OFS_PSC: s = ehrpc_pkg::SEL_PSC;
      `EHRPC_OFS_PWR: s = ehrpc_pkg::SEL_PWR;
      default:        s = ehrpc_pkg::SEL_NONE;
    endcase
    return s;
  endfunction : sel_of

  logic                      aw_held_ff;
  logic                      w_held_ff;
  logic [`EHRPC_ADDR_W-1:0]  awaddr_ff;
  logic [`EHRPC_DATA_W-1:0]  wdata_ff;
  logic [3:0]                wstrb_ff;
  logic                      awready_ff;
  logic                      wready_ff;
  logic                      bvalid_ff;
  logic [1:0]                bresp_ff;
  logic                      arready_ff;
  logic                      rvalid_ff;
  logic [`EHRPC_DATA_W-1:0]  rdata_ff;
  logic [1:0]                rresp_ff;
  logic [`EHRPC_DATA_W-1:0]  wbe;
  logic                      aw_take;
  logic                      w_take;
  logic                      ar_take;
  logic                      wr_go;
  logic                      nxt_aw_held;
  logic                      nxt_w_held;
  logic                      nxt_bvalid;
  logic                      nxt_rvalid;
  ehrpc_pkg::ehrpc_sel_t     wsel;
  logic                      psc_wr;

  logic                      cf_ff;
  logic                      cf_prev_ff;
  logic                      owner_ff;
  logic                      pwr_ff;
  logic                      pe_ff;
  logic                      susp_ff;
  logic                      susp_pend_ff;
  logic                      fpr_ff;
  ehrpc_pkg::ehrpc_pst_t     pst_ff;
  ehrpc_pkg::ehrpc_pst_t     nxt_pst;
  logic [`EHRPC_CNT_W-1:0]   cnt_ff;
  logic [`EHRPC_CNT_W-1:0]   nxt_cnt;
  logic                      bus_reset_ff;
  logic                      block_ff;
  ehrpc_pkg::ehrpc_mode_t    mode_ff;

  logic                      wr_owner;
  logic                      wr_prst;
  logic                      wr_susp;
  logic                      wr_fpr;
  logic                      wr_pe;
  logic                      prst_rise;
  logic                      fpr_fall;
  logic                      cnt_done;
  logic                      rst_done;
  logic                      res_done;
  logic                      prst_rd;
  ehrpc_pkg::ehrpc_root_port_status_control_t  psc_rd;
  logic [`EHRPC_DATA_W-1:0]  rd_val;
  ehrpc_pkg::ehrpc_sel_t     rsel;

  // Byte enables spread over the data word
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      assign wbe[g*8 +: 8] = {8{wstrb_ff[g]}};
    end
  endgenerate

  assign aw_take     = I_AWVALID & awready_ff;
  assign w_take      = I_WVALID & wready_ff;
  assign ar_take     = I_ARVALID & arready_ff;
  assign wr_go       = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign nxt_aw_held = (aw_held_ff | aw_take) & ~wr_go;
  assign nxt_w_held  = (w_held_ff | w_take) & ~wr_go;
  assign nxt_bvalid  = wr_go | (bvalid_ff & ~I_BREADY);
  assign nxt_rvalid  = ar_take | (rvalid_ff & ~I_RREADY);
  assign wsel        = sel_of(awaddr_ff);
  assign psc_wr      = wr_go & (wsel == ehrpc_pkg::SEL_PSC);

  assign wr_owner  = psc_wr & wbe[`EHRPC_B_OWNER];
  assign wr_prst   = psc_wr & wbe[`EHRPC_B_PRST];
  assign wr_susp   = psc_wr & wbe[`EHRPC_B_SUSP];
  assign wr_fpr    = psc_wr & wbe[`EHRPC_B_FPR];
  assign wr_pe     = psc_wr & wbe[`EHRPC_B_PE];
  assign prst_rise = wr_prst & wdata_ff[`EHRPC_B_PRST] & (pst_ff == ehrpc_pkg::PS_IDLE);
  assign fpr_fall  = wr_fpr & ~wdata_ff[`EHRPC_B_FPR] & fpr_ff;
  assign cnt_done  = (cnt_ff == `EHRPC_CNT_LAST);
  assign rst_done  = (pst_ff == ehrpc_pkg::PS_RST_END) & cnt_done & ~I_CONTROLLER_STOPPED_INDICATION;
  assign res_done  = (pst_ff == ehrpc_pkg::PS_RES_END) & cnt_done;
  assign prst_rd   = (pst_ff == ehrpc_pkg::PS_RESET) | (pst_ff == ehrpc_pkg::PS_RST_END);

  // Write address and data are accepted in either order
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      aw_held_ff <= 1'h0;
      w_held_ff  <= 1'h0;
      awready_ff <= 1'h0;
      wready_ff  <= 1'h0;
      bvalid_ff  <= 1'h0;
      bresp_ff   <= `EHRPC_RESP_OKAY;
      awaddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= 4'h0;
    end
    else
    begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
      bvalid_ff  <= nxt_bvalid;
      if (aw_take)
        awaddr_ff <= I_AWADDR;
      if (w_take)
      begin
        wdata_ff <= I_WDATA;
        wstrb_ff <= I_WSTRB;
      end
      if (wr_go)
        bresp_ff <= (wsel == ehrpc_pkg::SEL_NONE) ? `EHRPC_RESP_SLV : `EHRPC_RESP_OKAY;
    end
  end

  // Read channel answers one cycle after the address is taken
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      arready_ff <= 1'h0;
      rvalid_ff  <= 1'h0;
      rdata_ff   <= '0;
      rresp_ff   <= `EHRPC_RESP_OKAY;
    end
    else
    begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      if (ar_take)
      begin
        rdata_ff <= rd_val;
        rresp_ff <= (rsel == ehrpc_pkg::SEL_NONE) ? `EHRPC_RESP_SLV : `EHRPC_RESP_OKAY;
      end
    end
  end

  always_comb
  begin
    psc_rd         = '0;
    psc_rd.owner   = owner_ff;
    psc_rd.line    = {I_LINE_DP, I_LINE_DM};
    psc_rd.prst    = prst_rd & pwr_ff;
    psc_rd.susp    = susp_ff;
    psc_rd.fpr     = fpr_ff;
    psc_rd.pe      = pe_ff;
    psc_rd.ccs     = I_DEV_CONNECT & pwr_ff;
  end

  assign rsel = sel_of(I_ARADDR);

  always_comb
  begin
    rd_val = '0;
    unique case (rsel)
      ehrpc_pkg::SEL_STS: rd_val[`EHRPC_B_HALT] = I_CONTROLLER_STOPPED_INDICATION;
      ehrpc_pkg::SEL_CFG: rd_val[`EHRPC_B_CF]   = cf_ff;
      ehrpc_pkg::SEL_PSC: rd_val                = psc_rd;
      ehrpc_pkg::SEL_PWR: rd_val[`EHRPC_B_PWR]  = pwr_ff;
      ehrpc_pkg::SEL_NONE: rd_val               = '0;
    endcase
  end

  // Configured flag, port power and ownership
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      cf_ff      <= 1'h0;
      cf_prev_ff <= 1'h0;
      pwr_ff     <= `EHRPC_RST_PWR;
    end
    else
    begin
      cf_prev_ff <= cf_ff;
      if (wr_go && wsel == ehrpc_pkg::SEL_CFG && wstrb_ff[0])
        cf_ff <= wdata_ff[`EHRPC_B_CF];
      if (wr_go && wsel == ehrpc_pkg::SEL_PWR && wstrb_ff[0])
        pwr_ff <= wdata_ff[`EHRPC_B_PWR];
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
      owner_ff <= `EHRPC_RST_OWNER;
    else if (!cf_ff)
      owner_ff <= 1'h1;
    else if (!cf_prev_ff)
      owner_ff <= 1'h0;
    else if (wr_owner)
      owner_ff <= wdata_ff[`EHRPC_B_OWNER];
  end

  // Reset and resume sequencing
  always_comb
  begin
    nxt_pst = pst_ff;
    nxt_cnt = cnt_ff;
    unique case (pst_ff)
      ehrpc_pkg::PS_IDLE:
      begin
        nxt_cnt = `EHRPC_CNT_ZERO;
        if (prst_rise)
          nxt_pst = ehrpc_pkg::PS_RESET;
        else if (fpr_fall)
          nxt_pst = ehrpc_pkg::PS_RES_END;
      end
      ehrpc_pkg::PS_RESET:
      begin
        nxt_cnt = `EHRPC_CNT_ZERO;
        if (wr_prst && !wdata_ff[`EHRPC_B_PRST])
          nxt_pst = ehrpc_pkg::PS_RST_END;
      end
      ehrpc_pkg::PS_RST_END:
      begin
        if (rst_done)
          nxt_pst = ehrpc_pkg::PS_IDLE;
        else if (!cnt_done)
          nxt_cnt = cnt_ff + `EHRPC_CNT_ONE;
      end
      ehrpc_pkg::PS_RES_END:
      begin
        if (res_done)
          nxt_pst = ehrpc_pkg::PS_IDLE;
        else
          nxt_cnt = cnt_ff + `EHRPC_CNT_ONE;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST || !pwr_ff)
    begin
      pst_ff       <= ehrpc_pkg::PS_IDLE;
      cnt_ff       <= `EHRPC_CNT_ZERO;
      bus_reset_ff <= 1'h0;
    end
    else
    begin
      pst_ff       <= nxt_pst;
      cnt_ff       <= nxt_cnt;
      bus_reset_ff <= (nxt_pst == ehrpc_pkg::PS_RESET) || (nxt_pst == ehrpc_pkg::PS_RST_END);
    end
  end

  // Port enable
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST || !pwr_ff)
      pe_ff <= 1'h0;
    else if (prst_rise)
      pe_ff <= 1'h0;
    else if (rst_done)
      pe_ff <= I_DEV_HIGH_SPEED;
    else if (!I_DEV_CONNECT)
      pe_ff <= 1'h0;
    else if (wr_pe && !wdata_ff[`EHRPC_B_PE])
      pe_ff <= 1'h0;
  end

  // Suspend is requested, then entered once the bus is quiet
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST || !pwr_ff)
    begin
      susp_ff      <= 1'h0;
      susp_pend_ff <= 1'h0;
    end
    else if (prst_rise || fpr_fall || !pe_ff)
    begin
      susp_ff      <= 1'h0;
      susp_pend_ff <= 1'h0;
    end
    else if (susp_pend_ff && !I_XACT_BUSY)
    begin
      susp_ff      <= 1'h1;
      susp_pend_ff <= 1'h0;
    end
    else if (wr_susp && wdata_ff[`EHRPC_B_SUSP] && !susp_ff)
      susp_pend_ff <= 1'h1;
  end

  // Force resume is set by software or by resume seen while suspended
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST || !pwr_ff)
      fpr_ff <= 1'h0;
    else if (susp_ff && I_RESUME_DET)
      fpr_ff <= 1'h1;
    else if (res_done)
      fpr_ff <= 1'h0;
    else if (wr_fpr && wdata_ff[`EHRPC_B_FPR] && susp_ff)
      fpr_ff <= 1'h1;
  end

  // Port state and downstream blocking
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      mode_ff  <= ehrpc_pkg::MODE_DIS;
      block_ff <= 1'h1;
    end
    else
    begin
      if (!pe_ff)
        mode_ff <= ehrpc_pkg::MODE_DIS;
      else if (susp_ff)
        mode_ff <= ehrpc_pkg::MODE_SUSP;
      else
        mode_ff <= ehrpc_pkg::MODE_EN;
      block_ff <= ~pe_ff | susp_ff;
    end
  end

  assign O_AWREADY      = awready_ff;
  assign O_WREADY       = wready_ff;
  assign O_BVALID       = bvalid_ff;
  assign O_BRESP        = bresp_ff;
  assign O_ARREADY      = arready_ff;
  assign O_RVALID       = rvalid_ff;
  assign O_RDATA        = rdata_ff;
  assign O_RRESP        = rresp_ff;
  assign O_PORT_OWNER   = owner_ff;
  assign O_BUS_RESET    = bus_reset_ff;
  assign O_RESUME_DRIVE = fpr_ff;
  assign O_DS_BLOCK     = block_ff;
  assign O_PORT_MODE    = mode_ff;

endmodule : ehrpc_top
`default_nettype wire

/* File: testbench/ehrpc_properties.sv */
// Checker of the root port control behaviour, bound to the top module
`timescale 1ns/1ps
`default_nettype none
`include "ehrpc_params.svh"
module ehrpc_properties
(
  input wire logic                         I_SYS_CLK,
  input wire logic                         I_RST,
  input wire logic                         I_AWVALID,
  input wire logic                         O_AWREADY,
  input wire logic [`EHRPC_ADDR_W-1:0]     I_AWADDR,
  input wire logic                         I_WVALID,
  input wire logic                         O_WREADY,
  input wire logic [`EHRPC_DATA_W-1:0]     I_WDATA,
  input wire logic [3:0]                   I_WSTRB,
  input wire logic                         I_DEV_CONNECT,
  input wire logic                         I_DEV_HIGH_SPEED,
  input wire logic                         I_XACT_BUSY,
  input wire logic                         I_RESUME_DET,
  input wire logic                         O_PORT_OWNER,
  input wire logic                         O_BUS_RESET,
  input wire logic                         O_RESUME_DRIVE,
  input wire logic                         O_DS_BLOCK,
  input wire ehrpc_pkg::ehrpc_mode_t       O_PORT_MODE
);
  default clocking dc @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RST);
  chk_reset_start: assert property (
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY && I_AWADDR == `EHRPC_OFS_PSC
    && I_WSTRB[1] && I_WDATA[`EHRPC_B_PRST] && !O_BUS_RESET |-> ##[1:3] O_BUS_RESET)
    else $error("bus reset not started");
  chk_hs_enable: assert property (
    $fell(O_BUS_RESET) && I_DEV_HIGH_SPEED && I_DEV_CONNECT
    |-> ##[0:2] O_PORT_MODE == ehrpc_pkg::MODE_EN)
    else $error("high speed port not enabled");
  chk_fs_disabled: assert property (
    $fell(O_BUS_RESET) && !I_DEV_HIGH_SPEED |=> (O_PORT_MODE == ehrpc_pkg::MODE_DIS)[*2])
    else $error("slow port enabled");
  chk_block_en: assert property (
    (O_PORT_MODE == ehrpc_pkg::MODE_EN)[*2] |-> !O_DS_BLOCK)
    else $error("enabled port blocked");
  chk_block_off: assert property (
    (O_PORT_MODE != ehrpc_pkg::MODE_EN)[*2] |-> O_DS_BLOCK)
    else $error("idle port not blocked");
  chk_susp_idle: assert property (
    $rose(O_PORT_MODE == ehrpc_pkg::MODE_SUSP) |-> !$past(I_XACT_BUSY, 2))
    else $error("suspend entered mid transaction");
  chk_resume_watch: assert property (
    O_PORT_MODE == ehrpc_pkg::MODE_SUSP && I_RESUME_DET |-> ##[1:2] O_RESUME_DRIVE)
    else $error("resume not seen");
  chk_owner_reset: assert property (
    $fell(I_RST) |-> O_PORT_OWNER)
    else $error("owner not companion after reset");
  chk_reset_block: assert property (
    O_BUS_RESET[*3] |-> O_DS_BLOCK)
    else $error("data passes during bus reset");
endmodule : ehrpc_properties
bind ehrpc_top ehrpc_properties ehrpc_properties_inst (.I_SYS_CLK, .I_RST, .I_AWVALID,
  .O_AWREADY, .I_AWADDR, .I_WVALID, .O_WREADY, .I_WDATA, .I_WSTRB, .I_DEV_CONNECT,
  .I_DEV_HIGH_SPEED, .I_XACT_BUSY, .I_RESUME_DET, .O_PORT_OWNER, .O_BUS_RESET,
  .O_RESUME_DRIVE, .O_DS_BLOCK, .O_PORT_MODE);
`default_nettype wire

/* File: testbench/ehrpc_usb_dev.sv */
// Behavioural model of the device attached to the root port
`timescale 1ns/1ps
`default_nettype none
module ehrpc_usb_dev
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_attach,
  input  wire logic [1:0] i_speed,
  input  wire logic       i_busy_req,
  input  wire logic       i_wake,
  input  wire logic       i_bus_reset,
  input  wire logic       i_ds_block,
  input  wire logic       i_resume_drive,
  output logic            o_dp,
  output logic            o_dm,
  output logic            o_connect,
  output logic            o_high_speed,
  output logic            o_xact_busy,
  output logic            o_resume_det
);
  logic hs_ff;
  // Detached or reset lines sit at the pull-down level
  assign {o_dp, o_dm} = (!i_attach || i_bus_reset) ? 2'h0 : ((i_speed == 2'h0) ? 2'h1 : 2'h2);
  assign o_connect = i_attach;
  assign o_high_speed = hs_ff;
  // Traffic flows only while the port passes data
  assign o_xact_busy = i_busy_req && !i_ds_block;
  // Remote wake goes out only onto a quiet blocked port
  assign o_resume_det = i_wake && i_ds_block && !i_resume_drive;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || !i_attach)
      hs_ff <= 1'h0;
    else if (i_bus_reset)
      hs_ff <= (i_speed == 2'h2);
  end
endmodule : ehrpc_usb_dev
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the root port control block
`timescale 1ns/1ps
`default_nettype none
`include "ehrpc_params.svh"
module testbench;
  logic I_SYS_CLK, I_RST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_CONTROLLER_STOPPED_INDICATION;
  logic [7:0] I_AWADDR, I_ARADDR;
  logic [31:0] I_WDATA, d;
  logic [3:0] I_WSTRB;
  logic [1:0] speed;
  logic attach, busy_req, wake;
  wire logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_PORT_OWNER, O_BUS_RESET;
  wire logic O_RESUME_DRIVE, O_DS_BLOCK, I_LINE_DP, I_LINE_DM, I_DEV_CONNECT;
  wire logic I_DEV_HIGH_SPEED, I_XACT_BUSY, I_RESUME_DET;
  wire logic [1:0] O_BRESP, O_RRESP;
  wire logic [31:0] O_RDATA;
  wire ehrpc_pkg::ehrpc_mode_t O_PORT_MODE;
  int err_total, cmp_count, m_owner, m_pe, m_susp, m_fpr, m_prst, m_pwr;
  ehrpc_top ehrpc_top_inst (.I_SYS_CLK, .I_RST, .I_AWVALID, .O_AWREADY, .I_AWADDR, .I_WVALID,
    .O_WREADY, .I_WDATA, .I_WSTRB, .O_BVALID, .I_BREADY, .O_BRESP, .I_ARVALID, .O_ARREADY,
    .I_ARADDR, .O_RVALID, .I_RREADY, .O_RDATA, .O_RRESP, .I_LINE_DP, .I_LINE_DM, .I_DEV_CONNECT,
    .I_DEV_HIGH_SPEED, .I_XACT_BUSY, .I_RESUME_DET, .I_CONTROLLER_STOPPED_INDICATION, .O_PORT_OWNER, .O_BUS_RESET,
    .O_RESUME_DRIVE, .O_DS_BLOCK, .O_PORT_MODE);
  ehrpc_usb_dev ehrpc_usb_dev_inst (.i_sys_clk(I_SYS_CLK), .i_rst(I_RST), .i_attach(attach),
    .i_speed(speed), .i_busy_req(busy_req), .i_wake(wake), .i_bus_reset(O_BUS_RESET),
    .i_ds_block(O_DS_BLOCK), .i_resume_drive(O_RESUME_DRIVE), .o_dp(I_LINE_DP),
    .o_dm(I_LINE_DM), .o_connect(I_DEV_CONNECT), .o_high_speed(I_DEV_HIGH_SPEED),
    .o_xact_busy(I_XACT_BUSY), .o_resume_det(I_RESUME_DET));
  initial
  begin
    I_SYS_CLK = 1'h0;
    forever #5 I_SYS_CLK = ~I_SYS_CLK;
  end
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic give_up();
    err_total++;
    test_done();
  endtask : give_up
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // Expected port word from the bench's own port state
  function automatic logic [31:0] exp_psc();
    logic [1:0] ln;
    ln = (!attach || m_prst != 0) ? 2'h0 : ((speed == 2'h0) ? 2'h1 : 2'h2);
    return {18'h0, m_owner[0], 1'h0, ln, 1'h0, m_prst[0], m_susp[0], m_fpr[0], 3'h0,
      m_pe[0], 1'h0, attach & m_pwr[0]};
  endfunction : exp_psc
  function automatic logic [31:0] wv(input int prst, input int susp, input int fpr, input int pe);
    return {18'h0, m_owner[0], 4'h0, prst[0], susp[0], fpr[0], 3'h0, pe[0], 2'h0};
  endfunction : wv
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
    int n;
    @(posedge I_SYS_CLK);
    I_AWVALID <= 1'h1;
    I_AWADDR <= a;
    I_WVALID <= 1'h1;
    I_WDATA <= dat;
    I_BREADY <= 1'h1;
    for (n = 0; n < 60; n++)
    begin
      @(posedge I_SYS_CLK);
      if (I_AWVALID === 1'h1 && O_AWREADY === 1'h1)
        I_AWVALID <= 1'h0;
      if (I_WVALID === 1'h1 && O_WREADY === 1'h1)
        I_WVALID <= 1'h0;
      if (O_BVALID === 1'h1)
        break;
    end
    I_BREADY <= 1'h0;
    if (n == 60)
      give_up();
    cmp({30'h0, O_BRESP}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge I_SYS_CLK);
    I_ARVALID <= 1'h1;
    I_ARADDR <= a;
    I_RREADY <= 1'h1;
    for (n = 0; n < 60; n++)
    begin
      @(posedge I_SYS_CLK);
      if (I_ARVALID === 1'h1 && O_ARREADY === 1'h1)
        I_ARVALID <= 1'h0;
      if (O_RVALID === 1'h1)
        break;
    end
    I_RREADY <= 1'h0;
    if (n == 60)
      give_up();
    cmp(O_RDATA, ed);
    cmp({30'h0, O_RRESP}, {30'h0, er});
  endtask : rd
  task automatic psc();
    rd(`EHRPC_OFS_PSC, exp_psc(), `EHRPC_RESP_OKAY);
  endtask : psc
  task automatic port_reset(input int halt);
    int n;
    m_prst = 1;
    m_pe = 0;
    m_susp = 0;
    wr(`EHRPC_OFS_PSC, wv(1, 0, 0, 0), `EHRPC_RESP_OKAY);
    psc();
    repeat (20) @(posedge I_SYS_CLK);
    I_CONTROLLER_STOPPED_INDICATION <= halt[0];
    wr(`EHRPC_OFS_PSC, wv(0, 0, 0, 0), `EHRPC_RESP_OKAY);
    psc();
    if (halt != 0)
    begin
      rd(`EHRPC_OFS_STS, 32'h1, `EHRPC_RESP_OKAY);
      repeat (1200) @(posedge I_SYS_CLK);
      cmp({31'h0, O_BUS_RESET}, 32'h1);
      I_CONTROLLER_STOPPED_INDICATION <= 1'h0;
    end
    for (n = 0; n < 2000 && O_BUS_RESET !== 1'h0; n++)
      @(posedge I_SYS_CLK);
    if (n == 2000)
      give_up();
    m_prst = 0;
    m_pe = (speed == 2'h2);
    psc();
  endtask : port_reset
  initial
  begin
    {I_RST, I_CONTROLLER_STOPPED_INDICATION, attach} = 3'h5;
    {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, busy_req, wake} = 7'h0;
    {I_AWADDR, I_ARADDR, I_WDATA, speed} = 50'h0;
    I_WSTRB = 4'hf;
    {m_owner, m_pe, m_susp, m_fpr, m_prst} = {32'h1, 128'h0};
    m_pwr = 1;
    void'($urandom(5));
    repeat (12) @(posedge I_SYS_CLK);
    I_RST <= 1'b0;
    rd(`EHRPC_OFS_CFG, 32'h0, `EHRPC_RESP_OKAY);
    rd(`EHRPC_OFS_PWR, 32'h1, `EHRPC_RESP_OKAY);
    rd(`EHRPC_OFS_STS, 32'h0, `EHRPC_RESP_OKAY);
    rd(8'h60, 32'h0, `EHRPC_RESP_SLV);
    wr(8'h60, 32'hffffffff, `EHRPC_RESP_SLV);
    for (int i = 3; i >= 0; i--)
    begin
      attach <= (i != 3);
      speed <= 2'(i);
      @(posedge I_SYS_CLK);
      psc();
    end
    m_owner = 0;
    wr(`EHRPC_OFS_PSC, wv(0, 0, 0, 0), `EHRPC_RESP_OKAY);
    m_owner = 1;
    psc();
    wr(`EHRPC_OFS_CFG, 32'h1, `EHRPC_RESP_OKAY);
    m_owner = 0;
    psc();
    m_owner = 1;
    wr(`EHRPC_OFS_PSC, wv(0, 0, 0, 0), `EHRPC_RESP_OKAY);
    psc();
    m_owner = 0;
    wr(`EHRPC_OFS_PSC, wv(0, 0, 0, 0), `EHRPC_RESP_OKAY);
    speed <= 2'h2;
    port_reset(0);
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom;
      d[13] = m_owner[0];
      d[8:6] = 3'h0;
      d[2] = 1'h1;
      wr(`EHRPC_OFS_PSC, d, `EHRPC_RESP_OKAY);
      psc();
    end
    busy_req <= 1'h1;
    wr(`EHRPC_OFS_PSC, wv(0, 1, 0, 1), `EHRPC_RESP_OKAY);
    psc();
    busy_req <= 1'h0;
    repeat (4) @(posedge I_SYS_CLK);
    m_susp = 1;
    psc();
    wr(`EHRPC_OFS_PSC, wv(0, 0, 0, 1), `EHRPC_RESP_OKAY);
    psc();
    wake <= 1'h1;
    repeat (4) @(posedge I_SYS_CLK);
    wake <= 1'h0;
    m_fpr = 1;
    psc();
    wr(`EHRPC_OFS_PSC, wv(0, 0, 0, 1), `EHRPC_RESP_OKAY);
    m_susp = 0;
    psc();
    repeat (1100) @(posedge I_SYS_CLK);
    m_fpr = 0;
    psc();
    wr(`EHRPC_OFS_PSC, wv(0, 1, 0, 1), `EHRPC_RESP_OKAY);
    repeat (4) @(posedge I_SYS_CLK);
    m_susp = 1;
    psc();
    speed <= 2'h1;
    port_reset(1);
    // Power loss in mid reset must drop the reset bit and the connect bit
    wr(`EHRPC_OFS_PSC, wv(1, 0, 0, 0), `EHRPC_RESP_OKAY);
    wr(`EHRPC_OFS_PWR, 32'h0, `EHRPC_RESP_OKAY);
    m_pwr = 0;
    psc();
    rd(`EHRPC_OFS_PWR, 32'h0, `EHRPC_RESP_OKAY);
    test_done();
  end
endmodule : testbench
`default_nettype wire
